// [hdl/ccw_pkg.sv]
// Shared constants for the cyclic wake timer block: register map, field
// positions, reset values, mode and setting codes, and timing figures.
// Assumes a 125 MHz system clock and a 32-bit APB register port.
package ccw_pkg;

  // Clock and timer tick
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 100000; // 0.1 ms timer resolution
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00; // wake_source_control + threshold
  localparam logic [7:0] A_TMR1 = 8'h04; // first_timer_control
  localparam logic [7:0] A_TMR2 = 8'h08; // second_timer_control
  localparam logic [7:0] A_HS1 = 8'h0c; // high_side_control_one
  localparam logic [7:0] A_HS2 = 8'h10; // high_side_control_two
  localparam logic [7:0] A_STS = 8'h14; // Sticky event status, write one to clear
  localparam logic [7:0] A_MSK = 8'h18; // Interrupt mask
  localparam logic [7:0] A_STATE = 8'h1c; // Live timer and regulator state

  // Field positions
  localparam int CTRL_WAKE_LSB = 0;
  localparam int CTRL_PEAK_BIT = 2;
  localparam int TMR_PER_LSB = 0;
  localparam int TMR_ON_LSB = 4;
  localparam int STS_SPI_FAIL = 2;

  // Reset values
  localparam logic [1:0] WAKE_RST = 2'h0;
  localparam logic PEAK_RST = 1'b0;
  localparam logic [2:0] PER_RST = 3'h0;
  localparam logic [2:0] ON_RST = 3'h0;
  localparam logic [1:0] HS_RST = 2'h0;
  localparam logic [2:0] MSK_RST = 3'h0;

  // Operating modes from the chip mode controller
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_FAILSAFE = 2'h3;

  // On-time codes that stop the timer at a static level
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h1;

  // High-side output source codes
  localparam logic [1:0] HS_OFF = 2'h0;
  localparam logic [1:0] HS_ON = 2'h1;
  localparam logic [1:0] HS_TMR1 = 2'h2;
  localparam logic [1:0] HS_TMR2 = 2'h3;

  // Periods in 0.1 ms ticks
  localparam logic [14:0] PER_10_MS = 15'h0064;
  localparam logic [14:0] PER_20_MS = 15'h00c8;
  localparam logic [14:0] PER_50_MS = 15'h01f4;
  localparam logic [14:0] PER_100_MS = 15'h03e8;
  localparam logic [14:0] PER_200_MS = 15'h07d0;
  localparam logic [14:0] PER_1_S = 15'h2710;
  localparam logic [14:0] PER_2_S = 15'h4e20;

  // On-times in 0.1 ms ticks
  localparam logic [14:0] ON_0P1_MS = 15'h0001;
  localparam logic [14:0] ON_0P3_MS = 15'h0003;
  localparam logic [14:0] ON_1P0_MS = 15'h000a;
  localparam logic [14:0] ON_10_MS = 15'h0064;
  localparam logic [14:0] ON_20_MS = 15'h00c8;

  // Period code to length; spare code 7 behaves as the longest period
  function automatic logic [14:0] per_len(input logic [2:0] code);
    case (code)
      3'h0: per_len = PER_10_MS;
      3'h1: per_len = PER_20_MS;
      3'h2: per_len = PER_50_MS;
      3'h3: per_len = PER_100_MS;
      3'h4: per_len = PER_200_MS;
      3'h5: per_len = PER_1_S;
      default: per_len = PER_2_S;
    endcase
  endfunction

  // On-time code to length; spare code 7 behaves as the longest on-time
  function automatic logic [14:0] on_len(input logic [2:0] code);
    case (code)
      3'h2: on_len = ON_0P1_MS;
      3'h3: on_len = ON_0P3_MS;
      3'h4: on_len = ON_1P0_MS;
      3'h5: on_len = ON_10_MS;
      default: on_len = ON_20_MS;
    endcase
  endfunction

endpackage

// [hdl/ccw_timer.sv]
// One periodic timer: period counter, on-time phase and on-time start pulse.
// Assumes a one-cycle 0.1 ms tick and a start pulse on every config write.
module ccw_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [2:0] i_per,
  input wire logic [2:0] i_on,
  // Status
  output logic o_run,
  output logic o_lvl,
  output logic o_pulse
);

  // Whole timer state
  typedef struct packed {
    logic run;
    logic lvl;
    logic pls;
    logic [14:0] cnt;
  } ccw_tmr_s;

  ccw_tmr_s s_r;
  ccw_tmr_s s_nxt;
  logic [14:0] plen; // Selected period in ticks
  logic [14:0] olen; // Selected on-time in ticks
  logic is_off; // On-time code is one of the static settings

  assign plen = ccw_pkg::per_len(i_per);
  assign olen = ccw_pkg::on_len(i_on);
  assign is_off = (i_on == ccw_pkg::ON_OFF_LOW) || (i_on == ccw_pkg::ON_OFF_HIGH);

  // Next state of the timer
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pls = 1'b0;
    if (i_start)
    begin
      // Any write restarts the count; the start itself is never signalled
      s_nxt.cnt = 15'h0000;
      if (is_off)
      begin
        // Static level, timer stopped
        s_nxt.run = 1'b0;
        s_nxt.lvl = (i_on == ccw_pkg::ON_OFF_HIGH);
      end
      else
      begin
        // On-time phase begins right away
        s_nxt.run = 1'b1;
        s_nxt.lvl = 1'b1;
      end
    end
    else if (s_r.run && i_tick)
    begin
      if (s_r.cnt == plen - 15'h0001)
      begin
        // Period wrap: new on-time phase, announced
        s_nxt.cnt = 15'h0000;
        s_nxt.lvl = 1'b1;
        s_nxt.pls = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 15'h0001;
        // On-time over; an on-time not shorter than the period stays high
        if (s_r.cnt + 15'h0001 == olen)
        begin
          s_nxt.lvl = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_run = s_r.run;
  assign o_lvl = s_r.lvl;
  assign o_pulse = s_r.pls;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_start_runs: assert property (i_start && !is_off |=> o_run && o_lvl && s_r.cnt == 15'h0000)
    else $error("Timer did not start on on-time write");
  a_pulse_on_wrap: assert property (o_pulse |-> $past(i_tick) && $past(s_r.run) &&
    ($past(s_r.cnt) == $past(plen) - 15'h0001) && !$past(i_start))
    else $error("On-time start pulse without a period wrap");
  a_static_level: assert property (i_start && is_off |=>
    !o_run && o_lvl == ($past(i_on) == ccw_pkg::ON_OFF_HIGH) && !o_pulse)
    else $error("Static setting did not hold its level");
  a_on_end: assert property (s_r.run && i_tick && !i_start && olen < plen &&
    s_r.cnt + 15'h0001 == olen |=> !o_lvl)
    else $error("On-time phase did not end");

endmodule

// [hdl/ccw_top.sv]
// Cyclic wake timers with APB registers, interrupt and main regulator control.
// Assumes the mode input comes from logic on the same clock and the two
// load comparators come from the analog regulator, unsynchronised.
module ccw_top #(
  parameter int P_TICK_CYC = ccw_pkg::TICK_CYC // Cycles per 0.1 ms tick
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Chip mode and load comparators
  input wire logic [1:0] I_SBC_MODE,
  input wire logic I_LOAD_ABOVE_PEAK,
  input wire logic I_LOAD_BELOW_PEAK,
  // Regulator control
  output logic O_REG_EN,
  output logic O_REG_HP_EN,
  output logic O_PEAK_TH_SEL,
  // High-side switch drive
  output logic [3:0] O_HS,
  // Interrupts
  output logic O_IRQ,
  output logic O_INT_N
);

  // Divider cannot serve a zero or over-wide tick
  if (P_TICK_CYC < 1 || P_TICK_CYC > 65536)
  begin : g_bad_tick
    $error("P_TICK_CYC out of range");
  end

  localparam logic [15:0] TDIV_MAX = 16'(P_TICK_CYC - 1);

  // Whole block state
  typedef struct packed {
    logic [1:0] wake_en; // Timers enabled as wake sources
    logic peak; // Peak threshold select
    logic [1:0][2:0] per; // Period codes
    logic [1:0][2:0] on; // On-time codes
    logic [3:0][1:0] hs_cfg; // Source of each high-side output
    logic [2:0] sts; // Sticky events
    logic [2:0] msk; // Interrupt mask
    logic [1:0] start; // Timer restart pulses
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic int_n;
    logic [3:0] hs;
    logic reg_en;
    logic hp;
    logic [1:0] rise_s; // Comparator synchronisers
    logic [1:0] fall_s;
    logic [15:0] tdiv; // Tick divider
    logic tick;
  } ccw_top_s;

  ccw_top_s r;
  ccw_top_s s;
  logic [1:0] tmr_run; // Timer running
  logic [1:0] tmr_lvl; // Timer output level
  logic [1:0] tmr_pls; // Timer on-time start pulse
  logic mode_ok; // Normal or stop mode
  logic acc; // APB access phase
  logic wr; // Write completes at this edge
  logic hit; // Address decodes

  assign mode_ok = (I_SBC_MODE == ccw_pkg::MODE_NORMAL) ||
    (I_SBC_MODE == ccw_pkg::MODE_STOP);
  assign acc = I_PSEL && I_PENABLE;
  assign wr = acc && r.pready && I_PWRITE && !r.pslverr;

  // Address decode
  always_comb
  begin
    case (I_PADDR)
      ccw_pkg::A_CTRL, ccw_pkg::A_TMR1, ccw_pkg::A_TMR2, ccw_pkg::A_HS1,
      ccw_pkg::A_HS2, ccw_pkg::A_STS, ccw_pkg::A_MSK, ccw_pkg::A_STATE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Two timers, one per channel
  for (genvar g = 0; g < 2; g++)
  begin : g_tmr
    ccw_timer u_tmr (
      .i_clk(I_SYS_CLK),
      .i_nrst(I_NRST),
      .i_tick(r.tick),
      .i_start(r.start[g]),
      .i_per(r.per[g]),
      .i_on(r.on[g]),
      .o_run(tmr_run[g]),
      .o_lvl(tmr_lvl[g]),
      .o_pulse(tmr_pls[g])
    );
  end

  // Next state of the whole block
  always_comb
  begin
    logic [2:0] sset;
    logic [2:0] sclr;
    logic [2:0] wcode;
    sset = 3'h0;
    sclr = 3'h0;
    wcode = 3'h0;
    s = r;
    s.start = 2'h0;
    s.tick = 1'b0;
    s.pready = 1'b0;
    s.pslverr = 1'b0;
    // Comparators cross into the clock domain through two flops
    s.rise_s = {r.rise_s[0], I_LOAD_ABOVE_PEAK};
    s.fall_s = {r.fall_s[0], I_LOAD_BELOW_PEAK};
    // Free-running tick divider; first tick after a start may come early
    if (r.tdiv == TDIV_MAX)
    begin
      s.tdiv = 16'h0000;
      s.tick = 1'b1;
    end
    else
    begin
      s.tdiv = r.tdiv + 16'h0001;
    end
    // Access phase answers after one wait cycle, so ready is a flop
    if (acc && !r.pready)
    begin
      s.pready = 1'b1;
      s.pslverr = !hit;
      s.prdata = 32'h0000_0000;
      case (I_PADDR)
        ccw_pkg::A_CTRL: s.prdata[2:0] = {r.peak, r.wake_en};
        ccw_pkg::A_TMR1: s.prdata[6:0] = {r.on[0], 1'b0, r.per[0]};
        ccw_pkg::A_TMR2: s.prdata[6:0] = {r.on[1], 1'b0, r.per[1]};
        ccw_pkg::A_HS1: s.prdata[3:0] = {r.hs_cfg[1], r.hs_cfg[0]};
        ccw_pkg::A_HS2: s.prdata[3:0] = {r.hs_cfg[3], r.hs_cfg[2]};
        ccw_pkg::A_STS: s.prdata[2:0] = r.sts;
        ccw_pkg::A_MSK: s.prdata[2:0] = r.msk;
        ccw_pkg::A_STATE: s.prdata[5:0] = {r.hp, r.reg_en, tmr_lvl, tmr_run};
        default: s.prdata = 32'h0000_0000;
      endcase
    end
    // Register writes take effect at the completing edge
    if (wr)
    begin
      case (I_PADDR)
        ccw_pkg::A_CTRL:
        begin
          s.wake_en = I_PWDATA[ccw_pkg::CTRL_WAKE_LSB +: 2];
          s.peak = I_PWDATA[ccw_pkg::CTRL_PEAK_BIT];
        end
        ccw_pkg::A_TMR1, ccw_pkg::A_TMR2:
        begin
          wcode = I_PWDATA[ccw_pkg::TMR_ON_LSB +: 3];
          s.per[I_PADDR[3]] = I_PWDATA[ccw_pkg::TMR_PER_LSB +: 3];
          s.on[I_PADDR[3]] = wcode;
          s.start[I_PADDR[3]] = 1'b1;
          // Running on-time longer than the period is a setup failure
          if (wcode != ccw_pkg::ON_OFF_LOW && wcode != ccw_pkg::ON_OFF_HIGH &&
            ccw_pkg::on_len(wcode) > ccw_pkg::per_len(I_PWDATA[ccw_pkg::TMR_PER_LSB +: 3]))
          begin
            sset[ccw_pkg::STS_SPI_FAIL] = 1'b1;
          end
        end
        ccw_pkg::A_HS1: s.hs_cfg[1:0] = I_PWDATA[3:0];
        ccw_pkg::A_HS2: s.hs_cfg[3:2] = I_PWDATA[3:0];
        ccw_pkg::A_STS: sclr = I_PWDATA[2:0];
        ccw_pkg::A_MSK: s.msk = I_PWDATA[2:0];
        default: s.msk = r.msk;
      endcase
    end
    // Wake events only count in normal and stop mode
    sset[1:0] = tmr_pls & r.wake_en & {2{mode_ok}};
    // An event in the clearing cycle survives
    s.sts = (r.sts & ~sclr) | sset;
    // Interrupt lines follow unmasked status
    s.irq = |(r.sts & r.msk);
    s.int_n = !(|(r.sts & r.msk));
    // High-side sources
    for (int i = 0; i < 4; i++)
    begin
      case (r.hs_cfg[i])
        ccw_pkg::HS_ON: s.hs[i] = 1'b1;
        ccw_pkg::HS_TMR1: s.hs[i] = tmr_lvl[0];
        ccw_pkg::HS_TMR2: s.hs[i] = tmr_lvl[1];
        default: s.hs[i] = 1'b0;
      endcase
    end
    // Main regulator enable by mode
    s.reg_en = mode_ok;
    // High-power stage: always in normal, load driven in stop
    if (I_SBC_MODE == ccw_pkg::MODE_NORMAL)
    begin
      s.hp = 1'b1;
    end
    else if (I_SBC_MODE == ccw_pkg::MODE_STOP)
    begin
      if (r.rise_s[1])
      begin
        s.hp = 1'b1;
      end
      else if (r.fall_s[1])
      begin
        s.hp = 1'b0;
      end
    end
    else
    begin
      s.hp = 1'b0;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      r <= '0;
      r.wake_en <= ccw_pkg::WAKE_RST;
      r.peak <= ccw_pkg::PEAK_RST;
      r.per <= {2{ccw_pkg::PER_RST}};
      r.on <= {2{ccw_pkg::ON_RST}};
      r.hs_cfg <= {4{ccw_pkg::HS_RST}};
      r.msk <= ccw_pkg::MSK_RST;
      r.int_n <= 1'b1;
    end
    else
    begin
      r <= s;
    end
  end

  // Outputs straight from flops
  assign O_PRDATA = r.prdata;
  assign O_PREADY = r.pready;
  assign O_PSLVERR = r.pslverr;
  assign O_REG_EN = r.reg_en;
  assign O_REG_HP_EN = r.hp;
  assign O_PEAK_TH_SEL = r.peak;
  assign O_HS = r.hs;
  assign O_IRQ = r.irq;
  assign O_INT_N = r.int_n;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_NRST);

  sequence seq_stop_load_up;
    (I_LOAD_ABOVE_PEAK && I_SBC_MODE == ccw_pkg::MODE_STOP) ##1
    (I_SBC_MODE == ccw_pkg::MODE_STOP) [*2];
  endsequence

  sequence seq_bad_tmr_wr;
    wr && (I_PADDR == ccw_pkg::A_TMR1 || I_PADDR == ccw_pkg::A_TMR2) &&
    I_PWDATA[6:4] > ccw_pkg::ON_OFF_HIGH &&
    ccw_pkg::on_len(I_PWDATA[6:4]) > ccw_pkg::per_len(I_PWDATA[2:0]);
  endsequence

  a_wake_event: assert property (tmr_pls[0] && r.wake_en[0] && mode_ok |=> r.sts[0])
    else $error("Wake event did not set status");
  a_int_low: assert property (r.sts[0] && r.msk[0] |=> !O_INT_N && O_IRQ)
    else $error("Interrupt line not asserted");
  a_hs_follow: assert property (r.hs_cfg[0] == ccw_pkg::HS_TMR1 |=> O_HS[0] == $past(tmr_lvl[0]))
    else $error("High-side output not following timer");
  a_reg_mode: assert property (1'b1 |=> O_REG_EN == $past(mode_ok))
    else $error("Regulator enable wrong for mode");
  a_hp_normal: assert property (I_SBC_MODE == ccw_pkg::MODE_NORMAL |=> O_REG_HP_EN)
    else $error("High-power stage off in normal mode");
  a_hp_stop: assert property (seq_stop_load_up |=> O_REG_HP_EN)
    else $error("High-power stage not raised on load");
  a_peak_reset: assert property ($rose(I_NRST) |-> !O_PEAK_TH_SEL)
    else $error("Threshold select not low after reset");
  a_spi_fail: assert property (seq_bad_tmr_wr |=> r.sts[ccw_pkg::STS_SPI_FAIL])
    else $error("Failure flag not set");
  a_apb_ready: assert property (acc && !O_PREADY |=> O_PREADY ##1 !O_PREADY)
    else $error("Ready not a single cycle");

endmodule

// [verification/ccw_host.sv]
// Host controller model: APB master that the bench calls to reach registers.
// Assumes one shared clock with the block and a slave that raises pready.
module ccw_host (
  // Clock
  input wire logic i_clk,
  // APB answer from the block
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  // APB request to the block
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic timed_out; // Set when a slave never answers

  // Idle bus at time zero
  initial
  begin
    timed_out = 1'b0;
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end

  // One transfer; request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= addr;
    o_pwdata <= wd;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 50);
    if (i_pready !== 1'b1)
      timed_out = 1'b1;
    rd = i_prdata;
    err = i_pslverr;
    // Released lines show garbage so stale values are never trusted
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~addr;
    o_pwdata <= ~wd;
  endtask
endmodule

// [verification/cyclic_wake_timers_tb.sv]
// Self-checking bench for the cyclic wake timers with a host model on APB.
// Assumes a shortened tick of four clocks so periods stay short in simulation.
module cyclic_wake_timers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4; // Clocks per tick in this run
  logic sys_clk, nrst, ab, bl;
  logic [1:0] mode;
  logic psel, pen, pwr, prdy, perr, reg_en, hp, peak, irq, int_n;
  logic [7:0] paddr;
  logic [31:0] pwd, prd, r;
  logic [3:0] hs;
  logic e;
  int mismatches, num_checks, n, k, p, o;
  logic [31:0] seed = 32'd29162;
  // Reference figures in ticks, index is the field code
  int per_t[7] = '{100, 200, 500, 1000, 2000, 10000, 20000};
  int on_t[7] = '{0, 0, 1, 3, 10, 100, 200};

  ccw_top #(.P_TICK_CYC(TK)) uut (.I_SYS_CLK(sys_clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd),
    .O_PREADY(prdy), .O_PSLVERR(perr), .I_SBC_MODE(mode), .I_LOAD_ABOVE_PEAK(ab),
    .I_LOAD_BELOW_PEAK(bl), .O_REG_EN(reg_en), .O_REG_HP_EN(hp), .O_PEAK_TH_SEL(peak),
    .O_HS(hs), .O_IRQ(irq), .O_INT_N(int_n));
  ccw_host host (.i_clk(sys_clk), .i_prdata(prd), .i_pready(prdy), .i_pslverr(perr),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwd));

  // Free running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Random source with a fixed start
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Register access; a hung bus ends the run
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, r, e);
    if (host.timed_out)
    begin
      mismatches++;
      test_done();
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim)
    begin
      mismatches++;
      test_done();
    end
  endtask

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    mode = 2'h0;
    ab = 1'b0;
    bl = 1'b0;
    cyc(16);
    nrst <= 1'b1;
    cyc(2);
    chk(32'(int_n), 1);
    chk(32'(peak), 0);
    // Reset values of all writable registers
    for (int a = 0; a < 7; a++)
    begin
      acc(1'b0, 8'(a * 4), 0);
      chk(r, 0);
    end
    acc(1'b0, 8'h20, 0);
    chk(32'({e, r[0]}), 2);
    // Regulator enable per mode, random loads where they must not matter
    for (int m = 0; m < 4; m++)
    begin
      @(posedge sys_clk);
      mode <= 2'(m);
      ab <= (m > 1) ? xs() % 2 : 1'b0;
      bl <= 1'b0;
      cyc(6);
      chk(32'(reg_en), 32'(m < 2));
      if (m != 1)
        chk(32'(hp), 32'(m == 0));
    end
    // Stop mode high-power stage follows the comparators
    @(posedge sys_clk);
    mode <= ccw_pkg::MODE_STOP;
    bl <= 1'b1;
    cyc(6);
    chk(32'(hp), 0);
    ab <= 1'b1;
    bl <= 1'b0;
    cyc(6);
    chk(32'(hp), 1);
    ab <= 1'b0;
    bl <= 1'b1;
    cyc(6);
    chk(32'(hp), 0);
    mode <= ccw_pkg::MODE_NORMAL;
    acc(1'b1, ccw_pkg::A_CTRL, 32'h4);
    cyc(2);
    chk(32'(peak), 1);
    // Host wake setup order
    acc(1'b1, ccw_pkg::A_TMR1, 0);
    acc(1'b1, ccw_pkg::A_TMR2, 0);
    acc(1'b1, ccw_pkg::A_CTRL, 32'h5);
    acc(1'b1, ccw_pkg::A_MSK, 32'h1);
    acc(1'b1, ccw_pkg::A_HS1, 32'he);
    // Each rewrite restarts; first on-start silent, later ones interrupt
    for (int c = 0; c < 5; c++)
    begin
      @(posedge sys_clk);
      mode <= 2'(c % 2);
      acc(1'b1, ccw_pkg::A_STS, 32'h7);
      acc(1'b1, ccw_pkg::A_TMR1, 32'(((c + 2) << 4) | c));
      wait_irq(per_t[c] * TK + 50);
      chk(32'(n >= per_t[c] * TK - TK && n <= per_t[c] * TK + 8), 1);
      chk(32'(int_n), 0);
      k = 0;
      while (hs[0] === 1'b1 && k < 1000)
      begin
        @(posedge sys_clk);
        k++;
      end
      chk(32'(k >= on_t[c + 2] * TK - 6 && k <= on_t[c + 2] * TK), 1);
      acc(1'b1, ccw_pkg::A_STS, 32'h1);
      cyc(3);
      chk(32'(irq), 0);
    end
    // No wake status in sleep mode
    mode <= ccw_pkg::MODE_SLEEP;
    acc(1'b1, ccw_pkg::A_STS, 32'h7);
    cyc(per_t[4] * TK + 200);
    acc(1'b0, ccw_pkg::A_STS, 0);
    chk(32'(r[1:0]), 0);
    mode <= ccw_pkg::MODE_NORMAL;
    // Static levels and high-side sources
    acc(1'b1, ccw_pkg::A_TMR1, 32'h10);
    acc(1'b1, ccw_pkg::A_TMR2, 32'h10);
    cyc(4);
    chk(32'(hs[1:0]), 3);
    acc(1'b1, ccw_pkg::A_TMR1, 0);
    acc(1'b1, ccw_pkg::A_HS2, 32'h1);
    cyc(4);
    chk(32'(hs[2:0]), 6);
    // Failure flag when on-time is longer than period
    acc(1'b1, ccw_pkg::A_STS, 32'h7);
    for (int i = 0; i < 4; i++)
    begin
      p = xs() % 7;
      o = (i == 0) ? 6 : 2 + xs() % 5;
      acc(1'b1, ccw_pkg::A_TMR2, 32'((o << 4) | p));
      cyc(2);
      acc(1'b0, ccw_pkg::A_STS, 0);
      chk(32'(r[2]), 32'(on_t[o] > per_t[p]));
      chk(32'(irq), 0);
      acc(1'b1, ccw_pkg::A_STS, 32'h4);
    end
    // Masked flag reaches the line once enabled
    acc(1'b1, ccw_pkg::A_TMR2, 32'h60);
    acc(1'b1, ccw_pkg::A_MSK, 32'h4);
    cyc(3);
    chk(32'({irq, int_n}), 2);
    acc(1'b1, ccw_pkg::A_STS, 32'h4);
    cyc(3);
    chk(32'({irq, int_n}), 1);
    test_done();
  end
endmodule
